// ==== inc/rtc_i2c_pkg.sv ====
`default_nettype none
package rtc_i2c_pkg;

  // ------------------------------------------------------------------
  // Address map of the two slave spaces
  // ------------------------------------------------------------------
  localparam logic [7:0] PTR_RESET = 8'h00;  // Pointer after reset
  localparam logic [7:0] REG_TOP   = 8'h2F;  // Last clock register
  localparam logic [7:0] MEM_TOP   = 8'h7F;  // Last user memory byte
  localparam int         MEM_DEPTH = 128;    // User memory bytes

  // ------------------------------------------------------------------
  // Address byte layout
  // ------------------------------------------------------------------
  localparam int         RW_BIT    = 0;      // Direction bit position
  localparam logic       RW_READ   = 1'b1;   // One requests a read

  // ------------------------------------------------------------------
  // Serial engine states
  // ------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,      // Waiting for a START
    ST_ID,        // Shifting in the address byte
    ST_ID_ACK,    // Acknowledging the address byte
    ST_WADR,      // Shifting in the word address
    ST_WADR_ACK,  // Acknowledging the word address
    ST_WDAT,      // Shifting in the data byte
    ST_WDAT_ACK,  // Acknowledging the data byte
    ST_RDAT,      // Shifting out a data byte
    ST_MACK,      // Sampling the master's acknowledge
    ST_SKIP       // Deaf until the next START
  } state_t;

endpackage
`default_nettype wire

// ==== logic/i2c_line_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module i2c_line_sync
  import rtc_i2c_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rstn,
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_backup,
  input  wire logic i_por_busy,
  output logic      o_scl_rise,
  output logic      o_scl_fall,
  output logic      o_start,
  output logic      o_stop,
  output logic      o_sda,
  output logic      o_backup,
  output logic      o_busy
);

  // ------------------------------------------------------------------
  // Two-stage synchronisers, one per pin
  // ------------------------------------------------------------------
  localparam int N = 4;
  logic [N-1:0] raw;     // Pin levels from outside
  logic [N-1:0] meta_q;  // First stage, read only by second
  logic [N-1:0] sync_q;  // Second stage, safe to use
  logic [1:0]   hist_q;  // Previous scl/sda for edge finding

  assign raw = {i_por_busy, i_backup, i_sda, i_scl};

  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_sync
      // Idle bus level is high, so reset to high
      always_ff @(posedge i_clk)
      begin
        if (!i_rstn)
        begin
          meta_q[g] <= 1'b1;
          sync_q[g] <= 1'b1;
        end
        else
        begin
          meta_q[g] <= raw[g];
          sync_q[g] <= meta_q[g];
        end
      end
    end
  endgenerate

  // Delayed copy of the synced lines
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      hist_q <= 2'h3;
    else
      hist_q <= sync_q[1:0];
  end

  // ------------------------------------------------------------------
  // Edge and condition decode
  // ------------------------------------------------------------------
  // START and STOP only count while scl stays high on both samples
  assign o_scl_rise = sync_q[0] & ~hist_q[0];
  assign o_scl_fall = ~sync_q[0] & hist_q[0];
  assign o_start    = sync_q[0] & hist_q[0] & hist_q[1] & ~sync_q[1];
  assign o_stop     = sync_q[0] & hist_q[0] & ~hist_q[1] & sync_q[1];
  assign o_sda      = sync_q[1];
  assign o_backup   = sync_q[2];
  assign o_busy     = sync_q[3];

endmodule
`default_nettype wire

// ==== logic/rtc_i2c_slave.sv ====
// What this block does
// - Address byte picks register or memory space
// - Address LSB one reads, zero writes
// - Compare the seven identifier bits, acknowledge only on match
// - Word address from master or pointer
// - Pointer starts at zero after power-up
// - Write: three bytes, each acknowledged
// - After write, go idle until START
// - Random read: dummy write, restart, read
// - Keep sending while master acknowledges
// - Data from pointer, pointer advances per byte
// - Register space pointer wraps to zero
// - Backup supply disables serial interface
// - Bytes travel most significant bit first
// - Release after eight bits, ack ninth
// - Wait for START, ignore during power-up
// - 128 byte memory via memory identifier
`timescale 1ns/1ns
`default_nettype none
module rtc_i2c_slave
  import rtc_i2c_pkg::*;
#(
  parameter logic [6:0] REG_ID = 7'h11,  // Arbitrary value
  parameter logic [6:0] MEM_ID = 7'h22   // Arbitrary value
)
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_o,
  output logic            o_sda_oe,
  input  wire logic       i_backup,
  input  wire logic       i_por_busy,
  output logic [7:0]      o_reg_addr,
  output logic [7:0]      o_reg_wdata,
  output logic            o_reg_we,
  input  wire logic [7:0] i_reg_rdata
);

  // ------------------------------------------------------------------
  // Synchronised bus view
  // ------------------------------------------------------------------
  logic scl_rise;  // Synced scl went high
  logic scl_fall;  // Synced scl went low
  logic start;     // START seen
  logic stop;      // STOP seen
  logic sda_s;     // Synced sda level
  logic backup_s;  // On backup supply
  logic busy_s;    // Power-up sequence running

  i2c_line_sync u_sync (
    .i_clk      (i_clk),
    .i_rstn     (i_rstn),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .i_backup   (i_backup),
    .i_por_busy (i_por_busy),
    .o_scl_rise (scl_rise),
    .o_scl_fall (scl_fall),
    .o_start    (start),
    .o_stop     (stop),
    .o_sda      (sda_s),
    .o_backup   (backup_s),
    .o_busy     (busy_s)
  );

  // ------------------------------------------------------------------
  // State and storage
  // ------------------------------------------------------------------
  state_t     state_q, state_d;  // Serial engine state
  logic [2:0] cnt_q, cnt_d;      // Bit count, ack flag in MACK
  logic [7:0] sh_q, sh_d;        // Shift register
  logic [7:0] ptr_q, ptr_d;      // Word pointer
  logic       mem_q, mem_d;      // Memory space selected
  logic       oe_q, oe_d;        // Pulling sda low
  logic       we_d;              // Register write strobe
  logic [7:0] wdata_d;           // Register write data
  logic [7:0] mem [MEM_DEPTH];   // User memory, kept in backup

  // ------------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------------
  logic [7:0] rx_byte;   // Byte with the bit now sampled
  logic       byte_end;  // Eighth bit sampled
  logic       id_reg;    // Address hits register space
  logic       id_mem;    // Address hits memory space
  logic       id_hit;    // Either identifier
  logic [7:0] top;       // Wrap point of the open space
  logic [7:0] ptr_nxt;   // Pointer after one byte
  logic [7:0] rdata;     // Byte at the pointer
  logic       load;      // Next read byte goes out
  logic       mem_we;    // Write into user memory
  logic       live;      // Interface powered

  assign rx_byte  = {sh_q[6:0], sda_s};
  assign byte_end = scl_rise & (cnt_q == 3'h7);
  assign id_reg   = rx_byte[7:1] == REG_ID;
  assign id_mem   = rx_byte[7:1] == MEM_ID;
  assign id_hit   = id_reg | id_mem;
  assign top      = mem_q ? MEM_TOP : REG_TOP;
  assign ptr_nxt  = (ptr_q == top) ? PTR_RESET : ptr_q + 8'h01;
  assign rdata    = mem_q ? mem[ptr_q[6:0]] : i_reg_rdata;
  assign live     = ~backup_s;
  assign mem_we   = live & ~start & (state_q == ST_WDAT) & byte_end & mem_q;

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  // Bits move on synced scl edges, so sda changes land while scl is low
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    sh_d    = sh_q;
    ptr_d   = ptr_q;
    mem_d   = mem_q;
    oe_d    = oe_q;
    we_d    = 1'b0;
    wdata_d = o_reg_wdata;
    load    = 1'b0;
    case (state_q)
      // Receive states shift one bit per rising scl
      ST_ID, ST_WADR, ST_WDAT:
      begin
        if (scl_rise)
        begin
          sh_d  = rx_byte;
          cnt_d = cnt_q + 3'h1;
        end
        if (byte_end && state_q == ST_ID)
        begin
          // Decide only once all eight bits are in
          mem_d   = id_mem;
          state_d = id_hit ? ST_ID_ACK : ST_SKIP;
        end
        else if (byte_end && state_q == ST_WADR)
        begin
          ptr_d   = rx_byte;
          state_d = ST_WADR_ACK;
        end
        else if (byte_end)
        begin
          we_d    = ~mem_q;
          wdata_d = rx_byte;
          state_d = ST_WDAT_ACK;
        end
      end
      // Ack: pull low on first fall, release on the next
      ST_ID_ACK, ST_WADR_ACK, ST_WDAT_ACK:
      begin
        if (scl_fall && !oe_q)
          oe_d = 1'b1;
        else if (scl_fall)
        begin
          oe_d  = 1'b0;
          cnt_d = 3'h0;
          if (state_q == ST_WDAT_ACK)
          begin
            ptr_d   = ptr_nxt;
            state_d = ST_SKIP;
          end
          else if (state_q == ST_WADR_ACK)
            state_d = ST_WDAT;
          else if (sh_q[RW_BIT] == RW_READ)
            load = 1'b1;
          else
            state_d = ST_WADR;
        end
      end
      // Transmit: next bit on each fall, release after eight
      ST_RDAT:
      begin
        if (scl_rise)
          cnt_d = cnt_q + 3'h1;
        if (scl_fall && cnt_q == 3'h0)
        begin
          oe_d    = 1'b0;
          state_d = ST_MACK;
        end
        else if (scl_fall)
        begin
          sh_d = {sh_q[6:0], 1'b0};
          oe_d = ~sh_q[6];
        end
      end
      // Master ack continues, no-ack ends the read
      ST_MACK:
      begin
        if (scl_rise && sda_s)
          state_d = ST_SKIP;
        else if (scl_rise)
          cnt_d = 3'h1;
        else if (scl_fall && cnt_q == 3'h1)
          load = 1'b1;
      end
      default:
      begin
        state_d = state_q;
      end
    endcase
    // Shared byte load; the pointer advances as each byte goes out
    if (load)
    begin
      sh_d    = rdata;
      oe_d    = ~rdata[7];
      ptr_d   = ptr_nxt;
      cnt_d   = 3'h0;
      state_d = ST_RDAT;
    end
    // START restarts from anywhere, also for repeated START
    if (start && !busy_s)
    begin
      state_d = ST_ID;
      cnt_d   = 3'h0;
      oe_d    = 1'b0;
      we_d    = 1'b0;
    end
    else if (stop)
    begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
    end
    // Backup power parks the engine with the line released
    if (!live)
    begin
      state_d = ST_IDLE;
      oe_d    = 1'b0;
      we_d    = 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Control state, synchronous reset
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      state_q     <= ST_IDLE;
      cnt_q       <= 3'h0;
      sh_q        <= 8'h00;
      ptr_q       <= PTR_RESET;
      mem_q       <= 1'b0;
      oe_q        <= 1'b0;
      o_reg_we    <= 1'b0;
      o_reg_wdata <= 8'h00;
    end
    else
    begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      sh_q        <= sh_d;
      ptr_q       <= ptr_d;
      mem_q       <= mem_d;
      oe_q        <= oe_d;
      o_reg_we    <= we_d;
      o_reg_wdata <= wdata_d;
    end
  end

  // Memory has no reset: contents must survive everything
  always_ff @(posedge i_clk)
  begin
    if (mem_we)
      mem[ptr_q[6:0]] <= rx_byte;
  end

  // Open drain: the output value is always low
  always_ff @(posedge i_clk)
  begin
    o_sda_o <= 1'b0;
  end

  assign o_sda_oe   = oe_q;
  assign o_reg_addr = ptr_q;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_ptr_reset;
    @(posedge i_clk) $rose(i_rstn) |-> ptr_q == PTR_RESET;
  endproperty
  a_ptr_reset: assert property (p_ptr_reset) else $error("pointer not zero");

  property p_no_hit;
    @(posedge i_clk) disable iff (!i_rstn)
      state_q == ST_ID && byte_end && !id_hit && live && !start |=> state_q == ST_SKIP && !oe_q;
  endproperty
  a_no_hit: assert property (p_no_hit) else $error("unmatched id not ignored");

  property p_quiet;
    @(posedge i_clk) disable iff (!i_rstn)
      state_q == ST_IDLE || state_q == ST_SKIP |-> !o_sda_oe;
  endproperty
  a_quiet: assert property (p_quiet) else $error("line driven while idle");

  property p_backup;
    @(posedge i_clk) disable iff (!i_rstn)
      backup_s |=> !o_sda_oe && state_q == ST_IDLE;
  endproperty
  a_backup: assert property (p_backup) else $error("active in backup");

  property p_wrap;
    @(posedge i_clk) disable iff (!i_rstn)
      load && !mem_q && ptr_q == REG_TOP |=> ptr_q == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap at top");

  property p_advance;
    @(posedge i_clk) disable iff (!i_rstn)
      load && ptr_q != top |=> ptr_q == $past(ptr_q) + 8'h01;
  endproperty
  a_advance: assert property (p_advance) else $error("pointer did not advance");

  property p_start;
    @(posedge i_clk) disable iff (!i_rstn)
      start && !busy_s && live |=> state_q == ST_ID && cnt_q == 3'h0;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");

  property p_busy;
    @(posedge i_clk) disable iff (!i_rstn)
      busy_s && state_q == ST_IDLE |=> state_q == ST_IDLE;
  endproperty
  a_busy: assert property (p_busy) else $error("start taken in power-up");

  property p_nack;
    @(posedge i_clk) disable iff (!i_rstn)
      state_q == ST_MACK && scl_rise && sda_s && !start |=> state_q == ST_SKIP [*2] ##0 !o_sda_oe;
  endproperty
  a_nack: assert property (p_nack) else $error("no-ack did not end read");

  property p_write_done;
    @(posedge i_clk) disable iff (!i_rstn)
      state_q == ST_WDAT_ACK && scl_fall && oe_q && live && !start |=> state_q == ST_SKIP;
  endproperty
  a_write_done: assert property (p_write_done) else $error("write did not finish");

  property p_we_pulse;
    @(posedge i_clk) disable iff (!i_rstn)
      o_reg_we |-> !mem_q ##1 !o_reg_we;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("bad write strobe");

endmodule
`default_nettype wire

// ==== tb/i2c_master_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------------
// Bus master model: SCL period 8 clocks, SCL idles high between frames
// ------------------------------------------------------------------
module i2c_master_model
(
  input  wire logic i_clk,
  input  wire logic i_sda_bus,
  output logic      o_scl,
  output logic      o_sda
);
  // Released lines float high through the pull-ups
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  // Wait a number of quarter bus clocks
  task automatic q(input int n);
    repeat (2 * n) @(posedge i_clk);
  endtask

  // Start and repeated start; the long low phase lets the slave release its ack first
  task automatic start();
    q(2);
    o_sda <= 1'b1;
    q(2);
    o_scl <= 1'b1;
    q(2);
    o_sda <= 1'b0;
    q(2);
    o_scl <= 1'b0;
  endtask

  // Stop ends every frame; SCL then stands high
  task automatic stop();
    q(2);
    o_sda <= 1'b0;
    q(1);
    o_scl <= 1'b1;
    q(2);
    o_sda <= 1'b1;
    q(2);
  endtask

  // One byte MSB first, then the ninth clock with ack driven by ab
  task automatic xfer(input logic [7:0] tx, input logic ab, output logic [7:0] rx, output logic k);
    for (int i = 7; i >= 0; i--)
    begin
      q(1);
      o_sda <= tx[i];
      q(1);
      o_scl <= 1'b1;
      q(2);
      rx[i] = i_sda_bus;
      o_scl <= 1'b0;
    end
    q(1);
    o_sda <= ab;
    q(1);
    o_scl <= 1'b1;
    q(2);
    k = i_sda_bus;
    o_scl <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ==== tb/test_rtc_i2c_slave.sv ====
`timescale 1ns/1ns
`default_nettype none
module test_rtc_i2c_slave;
  import rtc_i2c_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  localparam logic [6:0] RID = 7'h35;  // Arbitrary value
  localparam logic [6:0] MID = 7'h4B;  // Arbitrary value
  logic       clk       = 1'b0;
  logic       rstn      = 1'b0;
  logic       backup    = 1'b0;
  logic       por_busy  = 1'b0;
  logic       scl;
  logic       m_sda;
  logic       sda_o;
  logic       sda_oe;
  wire logic  sda_bus;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_we;
  wire logic [7:0] reg_rdata;
  int         n_errors  = 0;
  int         num_checks = 0;
  int         we_cnt    = 0;
  logic [7:0] we_addr;
  logic [7:0] we_data;
  logic [7:0] d;
  int         c0;
  typedef struct packed {logic mem; logic [7:0] a; logic [7:0] dat; logic [7:0] e;} row_t;
  // Register rows read back addr^A5; memory rows read back what was written
  row_t rows [5] = '{'{1'b0, 8'h00, 8'h3C, 8'hA5}, '{1'b0, 8'h2F, 8'hC3, 8'h8A},
                     '{1'b1, 8'h00, 8'h11, 8'h11}, '{1'b1, 8'h7F, 8'hEE, 8'hEE},
                     '{1'b1, 8'h40, 8'h5A, 8'h5A}};

  always #2 clk = ~clk;
  // Wired-AND with pull-up
  assign sda_bus = m_sda & (sda_oe ? sda_o : 1'b1);
  // Clock-register side: fixed pattern so reads are predictable
  assign reg_rdata = reg_addr ^ 8'hA5;
  // Capture register write pulses
  always @(posedge clk)
  begin
    if (reg_we === 1'b1)
    begin
      we_cnt++;
      we_addr = reg_addr;
      we_data = reg_wdata;
    end
  end

  rtc_i2c_slave #(.REG_ID(RID), .MEM_ID(MID)) uut (
    .i_clk(clk), .i_rstn(rstn), .i_scl(scl), .i_sda(sda_bus), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_backup(backup), .i_por_busy(por_busy), .o_reg_addr(reg_addr), .o_reg_wdata(reg_wdata),
    .o_reg_we(reg_we), .i_reg_rdata(reg_rdata));
  i2c_master_model m (.i_clk(clk), .i_sda_bus(sda_bus), .o_scl(scl), .o_sda(m_sda));

  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // Send a byte and check the slave's ack bit (0 = ack)
  task automatic ack(input logic [7:0] b, input logic e);
    logic [7:0] r;
    logic       k;
    m.xfer(b, 1'b1, r, k);
    chk("ack", {7'h00, e}, {7'h00, k});
  endtask
  // Read one byte; last leaves the ninth bit high as a no-ack
  task automatic rdb(input logic last, output logic [7:0] v);
    logic k;
    m.xfer(8'hFF, last, v, k);
  endtask
  // Single-byte write: address byte, word address, data
  task automatic wr(input logic [6:0] id, input logic [7:0] a, input logic [7:0] v);
    m.start();
    ack({id, 1'b0}, 1'b0);
    ack(a, 1'b0);
    ack(v, 1'b0);
    m.stop();
  endtask
  // Dummy write of the pointer, repeated start, read address byte; same identifier both times
  task automatic point(input logic [6:0] id, input logic [7:0] a);
    m.start();
    ack({id, 1'b0}, 1'b0);
    ack(a, 1'b0);
    m.start();
    ack({id, 1'b1}, 1'b0);
  endtask
  // Current-address read of one register byte
  task automatic cur_read(input logic [7:0] e);
    m.start();
    ack({RID, 1'b1}, 1'b0);
    rdb(1'b1, d);
    m.stop();
    chk("current read", e, d);
  endtask
  task automatic finish_test();
    if (n_errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    #100000;
    n_errors++;
    finish_test();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    cur_read(8'hA5);
    // Row loop: single write, then random read back
    foreach (rows[i])
    begin
      c0 = we_cnt;
      wr(rows[i].mem ? MID : RID, rows[i].a, rows[i].dat);
      chk("we count", {7'h00, ~rows[i].mem}, 8'(we_cnt - c0));
      if (!rows[i].mem)
      begin
        chk("we addr", rows[i].a, we_addr);
        chk("we data", rows[i].dat, we_data);
      end
      point(rows[i].mem ? MID : RID, rows[i].a);
      rdb(1'b1, d);
      m.stop();
      chk("read", rows[i].e, d);
    end
    // Register space wrap in a sequential read
    point(RID, 8'h2E);
    rdb(1'b0, d);
    chk("seq 2E", 8'h8B, d);
    rdb(1'b0, d);
    chk("seq 2F", 8'h8A, d);
    rdb(1'b1, d);
    chk("seq wrap", 8'hA5, d);
    m.stop();
    // Memory space wrap from the top byte
    point(MID, 8'h7F);
    rdb(1'b0, d);
    chk("mem 7F", 8'hEE, d);
    rdb(1'b1, d);
    chk("mem wrap", 8'h11, d);
    // After the no-ack the slave must already have let go of the line
    chk("sda released", 8'h00, {7'h00, sda_oe});
    m.stop();
    // Identifier one bit off: no ack
    m.start();
    ack({RID ^ 7'h01, 1'b0}, 1'b1);
    m.stop();
    // Backup supply: interface dead, memory kept
    backup <= 1'b1;
    m.start();
    ack({RID, 1'b0}, 1'b1);
    m.stop();
    backup <= 1'b0;
    point(MID, 8'h40);
    rdb(1'b1, d);
    m.stop();
    chk("mem kept", 8'h5A, d);
    // Start during power-up sequence is ignored
    por_busy <= 1'b1;
    repeat (4) @(posedge clk);
    m.start();
    por_busy <= 1'b0;
    ack({RID, 1'b0}, 1'b1);
    m.stop();
    // Extra byte after write data refused, then standby
    c0 = we_cnt;
    m.start();
    ack({RID, 1'b0}, 1'b0);
    ack(8'h10, 1'b0);
    ack(8'h77, 1'b0);
    ack(8'h99, 1'b1);
    m.stop();
    chk("we once", 8'h01, 8'(we_cnt - c0));
    chk("we data", 8'h77, we_data);
    cur_read(8'hB4);
    // Reset in mid-run brings the pointer back to zero
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    cur_read(8'hA5);
    finish_test();
  end
endmodule
`default_nettype wire
